// [rtl/dssr_swap_ctrl.sv]
module dssr_swap_ctrl
  import dssr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Software control word write
  input wire logic cfg_wr_i,
  input wire logic [CFG_W-1:0] cfg_wdata_i,
  // Software readback
  output logic [CFG_W-1:0] cfg_rdata_o,
  // System state
  input wire logic memory_enabled_i,
  input wire logic channel_gang_enable_i,
  // Scrubber progress and rate
  input wire logic scrub_step_i,
  input wire logic scrub_ch_i,
  input wire logic [RANK_W-1:0] scrub_rank_i,
  input wire logic [RATE_W-1:0] scrub_rate_prog_i,
  output logic [RATE_W-1:0] scrub_rate_o,
  // Channel controller steering
  output logic [NUM_CH-1:0] spare_mirror_o,
  output logic [NUM_CH-1:0] spare_line_wr_o,
  output logic [NUM_CH-1:0] spare_redirect_o,
  output logic [RANK_W-1:0] failing_rank_select_ch0_o,
  output logic [RANK_W-1:0] failing_rank_select_ch1_o
);

  // ----------------------------------------------------------------
  // Per-channel control state
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] start_q;
  logic [NUM_CH-1:0] done_q;
  logic [RANK_W-1:0] rank_q [NUM_CH];
  logic [NUM_CH-1:0] busy;
  logic [NUM_CH-1:0] line_wr;
  logic [NUM_CH-1:0] finish;

  // ----------------------------------------------------------------
  // Per-channel field decode and engines
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam int SB = (ch == 0) ? START_CH0_BIT : START_CH1_BIT;
      localparam int DB = (ch == 0) ? DONE_CH0_BIT : DONE_CH1_BIT;
      localparam int RB = (ch == 0) ? RANK_CH0_LSB : RANK_CH1_LSB;
      localparam logic CH_ID = 1'(ch);
      logic wr_start;
      logic wr_done;
      logic own_step;

      dssr_copy_if cp ();

      assign wr_start = cfg_wr_i && cfg_wdata_i[SB];
      // Forced swap is refused while memory is live
      assign wr_done = cfg_wr_i && cfg_wdata_i[DB] &&
                       !memory_enabled_i;
      // Ganged channels share one scrubber sweep
      assign own_step = scrub_step_i &&
                        (channel_gang_enable_i ||
                         (scrub_ch_i == CH_ID));

      // Start bit: write-1-only, held until cold reset
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          start_q[ch] <= START_RST;
        end else if (wr_start) begin
          start_q[ch] <= 1'b1;
        end
      end

      // Complete flag: set by copy end or by software, cleared only by cold reset
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          done_q[ch] <= DONE_RST;
        end else if (finish[ch]) begin
          done_q[ch] <= 1'b1;
        end else if (wr_done) begin
          done_q[ch] <= 1'b1;
        end
      end

      // Failing rank field, frozen once the swap is in effect
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          rank_q[ch] <= RANK_RST;
        end else if (cfg_wr_i && !done_q[ch]) begin
          rank_q[ch] <= cfg_wdata_i[RB +: RANK_W];
        end
      end

      // Engine hookup
      assign cp.start = start_q[ch];
      assign cp.done = done_q[ch];
      assign cp.rank = rank_q[ch];
      assign cp.step = own_step;
      assign cp.scrub_rank = scrub_rank_i;
      assign busy[ch] = cp.busy;
      assign line_wr[ch] = cp.line_wr;
      assign finish[ch] = cp.finish;

      dssr_chan_copy u_copy (
        .ref_clk_i (ref_clk_i),
        .rst_b_i (rst_b_i),
        .cp (cp.eng)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  // Registered one cycle after the state it shows; reserved bits 0
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_rdata_o <= '0;
    end else begin
      cfg_rdata_o <= '0;
      cfg_rdata_o[START_CH0_BIT] <= start_q[0];
      cfg_rdata_o[DONE_CH0_BIT] <= done_q[0];
      cfg_rdata_o[START_CH1_BIT] <= start_q[1];
      cfg_rdata_o[DONE_CH1_BIT] <= done_q[1];
      cfg_rdata_o[RANK_CH0_LSB +: RANK_W] <= rank_q[0];
      cfg_rdata_o[RANK_CH1_LSB +: RANK_W] <= rank_q[1];
    end
  end

  // ----------------------------------------------------------------
  // Scrub rate
  // ----------------------------------------------------------------
  // One scrubber serves both channels, so either copy boosts it;
  // the programmed rate comes back the cycle after the copy ends.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scrub_rate_o <= RATE_RST;
    end else if (|busy) begin
      scrub_rate_o <= RATE_ACCEL;
    end else begin
      scrub_rate_o <= scrub_rate_prog_i;
    end
  end

  // ----------------------------------------------------------------
  // Channel controller steering
  // ----------------------------------------------------------------
  // Mirror only adds writes to the spare; traffic is never stalled
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spare_mirror_o <= '0;
    end else begin
      spare_mirror_o <= busy;
    end
  end

  // Line copy strobes, one cycle behind the engine
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spare_line_wr_o <= '0;
    end else begin
      spare_line_wr_o <= line_wr;
    end
  end

  // Redirect to spare only once the copy is whole or forced
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spare_redirect_o <= '0;
    end else begin
      spare_redirect_o <= done_q;
    end
  end

  // Failing rank seen by each channel controller
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      failing_rank_select_ch0_o <= RANK_RST;
      failing_rank_select_ch1_o <= RANK_RST;
    end else begin
      failing_rank_select_ch0_o <= rank_q[0];
      failing_rank_select_ch1_o <= rank_q[1];
    end
  end

endmodule : dssr_swap_ctrl

// [rtl/dssr_pkg.sv]
package dssr_pkg;

  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 11;
  localparam int START_CH0_BIT = 0;
  localparam int DONE_CH0_BIT = 1;
  localparam int START_CH1_BIT = 2;
  localparam int DONE_CH1_BIT = 3;
  localparam int RANK_CH0_LSB = 4;
  localparam int RANK_CH1_LSB = 8;
  localparam int RANK_W = 3;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 2;
  localparam int RATE_W = 5;
  localparam logic START_RST = 1'b0;
  localparam logic DONE_RST = 1'b0;
  localparam logic [RANK_W-1:0] RANK_RST = 3'h0;
  localparam logic [RATE_W-1:0] RATE_RST = 5'h00;
  // Accelerated scrub rate used while copying (arbitrary fast code)
  localparam logic [RATE_W-1:0] RATE_ACCEL = 5'h01;

  // ----------------------------------------------------------------
  // Copy engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_ENTER = 3'b010,
    ST_COPY = 3'b011,
    ST_FIN = 3'b100
  } dssr_state_t;

endpackage : dssr_pkg

// [rtl/dssr_copy_if.sv]
interface dssr_copy_if;
  import dssr_pkg::*;

  // Control from the register side
  logic start;
  logic done;
  logic [RANK_W-1:0] rank;
  // Scrubber progress seen by this channel
  logic step;
  logic [RANK_W-1:0] scrub_rank;
  // Engine answers
  logic busy;
  logic line_wr;
  logic finish;

  modport ctrl (
    output start, done, rank, step, scrub_rank,
    input busy, line_wr, finish
  );
  modport eng (
    input start, done, rank, step, scrub_rank,
    output busy, line_wr, finish
  );
endinterface : dssr_copy_if

// [rtl/dssr_chan_copy.sv]
module dssr_chan_copy
  import dssr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Link to the control registers
  dssr_copy_if.eng cp
);

  dssr_state_t state_q;
  dssr_state_t state_d;
  logic in_rank;

  // Scrub step that lands inside the failing rank
  assign in_rank = cp.step && (cp.scrub_rank == cp.rank);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Copy starts only at the first line of the rank so that one
  // sweep of the scrubber covers the whole rank exactly once.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cp.start && !cp.done) begin
          state_d = ST_SEEK;
        end
      end
      ST_SEEK: begin
        if (cp.step && !in_rank) begin
          state_d = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (in_rank) begin
          state_d = ST_COPY;
        end
      end
      ST_COPY: begin
        if (cp.step && !in_rank) begin
          state_d = ST_FIN;
        end
      end
      ST_FIN: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Software forced the swap: stop any copy at once
    if (cp.done) begin
      state_d = ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Busy from seek to the end of the sweep
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cp.busy <= 1'b0;
    end else begin
      cp.busy <= (state_d != ST_IDLE) && (state_d != ST_FIN);
    end
  end

  // One spare line write per scrubbed line of the rank
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cp.line_wr <= 1'b0;
    end else begin
      cp.line_wr <= in_rank && !cp.done &&
                    ((state_q == ST_ENTER) || (state_q == ST_COPY));
    end
  end

  // Completion pulse
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cp.finish <= 1'b0;
    end else begin
      cp.finish <= (state_d == ST_FIN);
    end
  end

endmodule : dssr_chan_copy

// [tb/dssr_swap_props.sv]
module dssr_swap_props
  import dssr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Software side
  input wire logic cfg_wr_i,
  input wire logic [CFG_W-1:0] cfg_wdata_i,
  input wire logic [CFG_W-1:0] cfg_rdata_o,
  input wire logic memory_enabled_i,
  // Scrubber and steering
  input wire logic scrub_step_i,
  input wire logic [RATE_W-1:0] scrub_rate_prog_i,
  input wire logic [RATE_W-1:0] scrub_rate_o,
  input wire logic [NUM_CH-1:0] spare_mirror_o,
  input wire logic [NUM_CH-1:0] spare_line_wr_o,
  input wire logic [NUM_CH-1:0] spare_redirect_o,
  input wire logic [RANK_W-1:0] failing_rank_select_ch0_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Guarded so a pending hardware completion cannot look like a set
  sequence blocked_set_s;
    cfg_wr_i && cfg_wdata_i[DONE_CH0_BIT] && memory_enabled_i
      && !cfg_rdata_o[1] && !spare_mirror_o[0]
      && !$past(spare_mirror_o[0]) && !$past(cfg_wr_i);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  start_sticky_a: assert property (cfg_rdata_o[0] |=> cfg_rdata_o[0])
    else $error("start bit dropped");
  done_sticky_a: assert property (cfg_rdata_o[1] |=> cfg_rdata_o[1])
    else $error("complete flag dropped");
  done_blocked_a: assert property (blocked_set_s |-> ##2 !cfg_rdata_o[1])
    else $error("complete set while memory enabled");
  rank_lock_a: assert property (cfg_rdata_o[1]
    |=> $stable(failing_rank_select_ch0_o))
    else $error("rank changed while complete");
  rate_fast_a: assert property (|spare_mirror_o
    |-> scrub_rate_o == RATE_ACCEL)
    else $error("scrub rate not boosted");
  rate_back_a: assert property (!(|spare_mirror_o)
    && !$past(|spare_mirror_o) && $past(rst_b_i)
    |-> scrub_rate_o == $past(scrub_rate_prog_i))
    else $error("scrub rate not restored");
  copy_end_a: assert property ($fell(spare_mirror_o[0])
    |-> ##[0:2] cfg_rdata_o[1])
    else $error("copy ended without complete");
  line_cause_a: assert property (spare_line_wr_o[0]
    |-> spare_mirror_o[0] && $past(scrub_step_i, 2))
    else $error("line copy without step");
  redirect_on_a: assert property (cfg_rdata_o[1]
    |-> spare_redirect_o[0])
    else $error("complete without redirect");
endmodule : dssr_swap_props

bind dssr_swap_ctrl dssr_swap_props u_props (
  .ref_clk_i(ref_clk_i),
  .rst_b_i(rst_b_i),
  .cfg_wr_i(cfg_wr_i),
  .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o),
  .memory_enabled_i(memory_enabled_i),
  .scrub_step_i(scrub_step_i),
  .scrub_rate_prog_i(scrub_rate_prog_i),
  .scrub_rate_o(scrub_rate_o),
  .spare_mirror_o(spare_mirror_o),
  .spare_line_wr_o(spare_line_wr_o),
  .spare_redirect_o(spare_redirect_o),
  .failing_rank_select_ch0_o(failing_rank_select_ch0_o)
);

// [tb/dssr_swap_ctrl_tb.sv]
module dssr_swap_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dssr_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wr = 1'b0;
  logic [10:0] wd = 11'h000;
  logic [10:0] rd;
  logic men = 1'b1;
  logic gang = 1'b0;
  logic stp = 1'b0;
  logic sch = 1'b0;
  logic [2:0] srk = 3'h0;
  logic [4:0] prog = 5'h0A;
  logic [4:0] rate;
  logic [1:0] mir, lwr, redir;
  logic [2:0] r0, r1;
  int n_fail = 0;
  int num_checks = 0;

  // 20 MHz clock
  always #25 ref_clk_i = ~ref_clk_i;

  dssr_swap_ctrl dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .cfg_wr_i(wr), .cfg_wdata_i(wd), .cfg_rdata_o(rd),
    .memory_enabled_i(men), .channel_gang_enable_i(gang),
    .scrub_step_i(stp), .scrub_ch_i(sch), .scrub_rank_i(srk),
    .scrub_rate_prog_i(prog), .scrub_rate_o(rate),
    .spare_mirror_o(mir), .spare_line_wr_o(lwr),
    .spare_redirect_o(redir), .failing_rank_select_ch0_o(r0),
    .failing_rank_select_ch1_o(r1)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [10:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // Wait n edges, then let updates settle
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : cyc

  task automatic wrw(input logic [10:0] w);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    wd <= w;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : wrw

  // One scrubbed line on channel c, rank k
  task automatic st(input logic c, input logic [2:0] k);
    @(posedge ref_clk_i);
    stp <= 1'b1;
    sch <= c;
    srk <= k;
    @(posedge ref_clk_i);
    stp <= 1'b0;
  endtask : st

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // Watchdog: every wait is fixed, this only guards a stuck run
  initial begin
    #200us;
    n_fail++;
    summarize();
  end

  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    cyc(1);
    chk("reset", rd, 11'h000);
    wrw(11'h352);
    cyc(2);
    chk("blocked", rd, 11'h350);
    chk("ranks", {5'h00, r1, r0}, 11'h01D);
    wrw(11'h351);
    cyc(3);
    chk("mirror", mir, 2'b01);
    chk("fast", rate, 5'h01);
    wrw(11'h350);
    cyc(2);
    chk("start", rd, 11'h351);
    // Sweep enters the rank from outside; line strobe stands one cycle
    st(1'b0, 3'h2);
    st(1'b0, 3'h5);
    cyc(1);
    chk("line1", lwr, 2'b01);
    st(1'b1, 3'h5);
    cyc(1);
    chk("other", lwr, 2'b00);
    st(1'b0, 3'h5);
    cyc(1);
    chk("line2", lwr, 2'b01);
    st(1'b0, 3'h2);
    cyc(2);
    chk("end", mir, 2'b00);
    cyc(1);
    chk("done", rd, 11'h353);
    chk("redir", redir, 2'b01);
    chk("slow", rate, 5'h0A);
    // Channel 0 rank write differs from the held value, must not land
    wrw(11'h620);
    cyc(2);
    chk("lock", rd, 11'h653);
    // Resume path: memory off, software sets complete on channel 1
    @(posedge ref_clk_i);
    men <= 1'b0;
    // Start and complete together: the copy must never begin
    wrw(11'h60C);
    cyc(3);
    chk("swset", rd, 11'h65F);
    chk("swredir", redir, 2'b11);
    chk("nocopy", mir, 2'b00);
    // Second cold reset, then a ganged copy stepped as channel 1
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    gang <= 1'b1;
    men <= 1'b1;
    cyc(2);
    chk("rst2", rd, 11'h000);
    @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    wrw(11'h225);
    cyc(2);
    chk("gmirror", mir, 2'b11);
    st(1'b1, 3'h0);
    st(1'b1, 3'h2);
    cyc(1);
    chk("gline", lwr, 2'b11);
    st(1'b1, 3'h3);
    cyc(3);
    chk("gdone", rd, 11'h22F);
    chk("gredir", redir, 2'b11);
    summarize();
  end
endmodule : dssr_swap_ctrl_tb
